// *** design/adc_test_pattern_map.svh ***
// register offsets, field positions, reset values and pattern words
`ifndef ADC_TEST_PATTERN_MAP_SVH
`define ADC_TEST_PATTERN_MAP_SVH

`define ADDR_PATTERN_SELECT   8'hC0
`define ADDR_PATTERN_RSVD     8'hC1
`define ADDR_PATTERN_ONE_LO   8'hC2
`define ADDR_PATTERN_ONE_HI   8'hC3
`define ADDR_PATTERN_TWO_LO   8'hC4
`define ADDR_PATTERN_TWO_HI   8'hC5
`define ADDR_OUTPUT_MODE_B    8'h74

`define RST_BYTE              8'h00
`define DDR_ENABLE_BIT        4

`define SEL_MODE_LSB          0
`define SEL_MODE_MSB          3
`define SEL_SEQ_LSB           6
`define SEL_SEQ_MSB           7

`define MODE_NORMAL           4'h0
`define MODE_MIDSCALE         4'h1
`define MODE_POS_FULL         4'h2
`define MODE_NEG_FULL         4'h3
`define MODE_CHECKER          4'h4
`define MODE_WORD_TOGGLE      4'h7
`define MODE_USER             4'h8

`define SEQ_SINGLE            2'h0
`define SEQ_ALTERNATE         2'h1

`define WORD_MIDSCALE         12'h800
`define WORD_ALL_ONES         12'hFFF
`define WORD_ALL_ZEROS        12'h000
`define WORD_CHECKER_A        12'hAAA
`define WORD_CHECKER_B        12'h555

`define SAMPLE_WIDTH          12
`define FIFO_DEPTH            16

`endif

// *** design/adc_test_pattern_pkg.sv ***
// types shared by the test pattern register bank
package adc_test_pattern_pkg;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_s;

	typedef enum logic [1:0] {
		PHASE_FIRST  = 2'b01,
		PHASE_SECOND = 2'b10
	} phase_e;

endpackage

// *** design/sample_fifo.sv ***
// synchronous valid/ready fifo with registered flags
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             in_ready,
	output var  logic             out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic [AW:0]      nxt_count;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign out_data  = mem[rd_ptr_ff];
	assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	// flags registered from the next count so neither side sees a comb path
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + AW'(push);
			rd_ptr_ff <= rd_ptr_ff + AW'(pop);
			count_ff  <= nxt_count;
			in_ready  <= nxt_count != (AW+1)'(DEPTH);
			out_valid <= nxt_count != '0;
		end
	end

	a_fifo_no_overflow: assert property (@(posedge clock) disable iff (!arst_n)
		count_ff <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

`default_nettype wire

// *** design/adc_test_pattern_regs.sv ***
// test pattern register bank and output word generator
`timescale 1ns/1ps
`default_nettype none
`include "adc_test_pattern_map.svh"

//////////////////////////////////////////////////////////////////////////////
module adc_test_pattern_regs (
	input  wire logic                               clock,
	input  wire logic                               arst_n,
	input  wire adc_test_pattern_pkg::reg_write_s   reg_wr,
	input  wire logic                               reg_rd_en,
	input  wire logic [7:0]                         reg_rd_addr,
	output var  logic [7:0]                         reg_rd_data,
	input  wire logic                               sample_valid,
	input  wire logic [`SAMPLE_WIDTH-1:0]           sample_data,
	output var  logic                               sample_ready,
	output var  logic                               out_valid,
	output var  logic [`SAMPLE_WIDTH-1:0]           out_data,
	input  wire logic                               out_ready,
	output var  logic                               ddr_enable
);
	//////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]                     select_ff;
	logic [15:0]                    pattern_one_ff;
	logic [15:0]                    pattern_two_ff;
	logic [7:0]                     output_mode_b_ff;
	logic [7:0]                     rd_data_ff;
	adc_test_pattern_pkg::phase_e   phase_ff;
	adc_test_pattern_pkg::phase_e   nxt_phase;

	// request passed in, so the continuous assigns re-evaluate when it moves
	function automatic logic hit(input adc_test_pattern_pkg::reg_write_s wr,
		input logic [7:0] addr);
		hit = wr.en && (wr.addr == addr);
	endfunction

	wire wr_select  = hit(reg_wr, `ADDR_PATTERN_SELECT);
	wire wr_one_lo  = hit(reg_wr, `ADDR_PATTERN_ONE_LO);
	wire wr_one_hi  = hit(reg_wr, `ADDR_PATTERN_ONE_HI);
	wire wr_two_lo  = hit(reg_wr, `ADDR_PATTERN_TWO_LO);
	wire wr_two_hi  = hit(reg_wr, `ADDR_PATTERN_TWO_HI);
	wire wr_mode_b  = hit(reg_wr, `ADDR_OUTPUT_MODE_B);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			select_ff        <= `RST_BYTE;
			pattern_one_ff   <= {`RST_BYTE, `RST_BYTE};
			pattern_two_ff   <= {`RST_BYTE, `RST_BYTE};
			output_mode_b_ff <= `RST_BYTE;
		end else begin
			if (wr_select) select_ff <= reg_wr.data;
			if (wr_one_lo) pattern_one_ff[7:0]  <= reg_wr.data;
			if (wr_one_hi) pattern_one_ff[15:8] <= reg_wr.data;
			if (wr_two_lo) pattern_two_ff[7:0]  <= reg_wr.data;
			if (wr_two_hi) pattern_two_ff[15:8] <= reg_wr.data;
			if (wr_mode_b) output_mode_b_ff <= reg_wr.data;
		end
	end

	assign ddr_enable = output_mode_b_ff[`DDR_ENABLE_BIT];

	//////////////////////////////////////////////////////////////////////////
	// read port: reserved and unmapped addresses read zero
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_rd_addr)
			`ADDR_PATTERN_SELECT: rd_mux = select_ff;
			`ADDR_PATTERN_ONE_LO: rd_mux = pattern_one_ff[7:0];
			`ADDR_PATTERN_ONE_HI: rd_mux = pattern_one_ff[15:8];
			`ADDR_PATTERN_TWO_LO: rd_mux = pattern_two_ff[7:0];
			`ADDR_PATTERN_TWO_HI: rd_mux = pattern_two_ff[15:8];
			`ADDR_OUTPUT_MODE_B:  rd_mux = output_mode_b_ff;
			default:              rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_ff <= 8'h00;
		end else if (reg_rd_en) begin
			rd_data_ff <= rd_mux;
		end
	end
	assign reg_rd_data = rd_data_ff;

	//////////////////////////////////////////////////////////////////////////
	// pattern generation
	wire [3:0] mode = select_ff[`SEL_MODE_MSB:`SEL_MODE_LSB];
	wire [1:0] seq  = select_ff[`SEL_SEQ_MSB:`SEL_SEQ_LSB];
	wire       alt  = (seq == `SEQ_ALTERNATE);
	wire       second = (phase_ff == adc_test_pattern_pkg::PHASE_SECOND);

	// user patterns are msb-justified: the low four bits never reach the bus
	wire [`SAMPLE_WIDTH-1:0] user_one = pattern_one_ff[15:4];
	wire [`SAMPLE_WIDTH-1:0] user_two = pattern_two_ff[15:4];
	wire [`SAMPLE_WIDTH-1:0] user_word = (alt && second) ? user_two : user_one;

	logic [`SAMPLE_WIDTH-1:0] push_word;
	always_comb begin
		case (mode)
			`MODE_MIDSCALE:    push_word = `WORD_MIDSCALE;
			`MODE_POS_FULL:    push_word = `WORD_ALL_ONES;
			`MODE_NEG_FULL:    push_word = `WORD_ALL_ZEROS;
			`MODE_CHECKER:     push_word = second ? `WORD_CHECKER_B : `WORD_CHECKER_A;
			`MODE_WORD_TOGGLE: push_word = second ? `WORD_ALL_ZEROS : `WORD_ALL_ONES;
			`MODE_USER:        push_word = user_word;
			// reserved codes pass live data rather than freezing the bus
			default:           push_word = sample_data;
		endcase
	end

	wire accept = sample_valid && sample_ready;

	// reserved sequence codes behave as single
	wire toggles = (mode == `MODE_CHECKER) || (mode == `MODE_WORD_TOGGLE)
		|| ((mode == `MODE_USER) && alt);

	always_comb begin
		case (phase_ff)
			adc_test_pattern_pkg::PHASE_FIRST:
				nxt_phase = (accept && toggles) ? adc_test_pattern_pkg::PHASE_SECOND
					: adc_test_pattern_pkg::PHASE_FIRST;
			adc_test_pattern_pkg::PHASE_SECOND:
				nxt_phase = (accept || !toggles) ? adc_test_pattern_pkg::PHASE_FIRST
					: adc_test_pattern_pkg::PHASE_SECOND;
			default:
				nxt_phase = adc_test_pattern_pkg::PHASE_FIRST;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			phase_ff <= adc_test_pattern_pkg::PHASE_FIRST;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// output buffer and registered output stage
	logic                     fifo_valid;
	logic [`SAMPLE_WIDTH-1:0] fifo_data;
	logic                     out_valid_ff;
	logic [`SAMPLE_WIDTH-1:0] out_data_ff;
	wire                      stage_load = !out_valid_ff || out_ready;

	sample_fifo #(
		.WIDTH (`SAMPLE_WIDTH),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.arst_n    (arst_n),
		.in_valid  (sample_valid),
		.in_data   (push_word),
		.in_ready  (sample_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (stage_load)
	);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			out_valid_ff <= 1'b0;
			out_data_ff  <= '0;
		end else if (stage_load) begin
			out_valid_ff <= fifo_valid;
			out_data_ff  <= fifo_data;
		end
	end
	assign out_valid = out_valid_ff;
	assign out_data  = out_data_ff;

	//////////////////////////////////////////////////////////////////////////
	// assertion helpers: last accepted toggling word, forgotten on leaving the mode
	// independent of the phase register, so a stuck phase still trips them
	wire  in_alt_user = (mode == `MODE_USER) && alt;
	logic prev_ones_ff;
	logic prev_alt_ff;
	logic prev_first_ff;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prev_ones_ff  <= 1'b0;
			prev_alt_ff   <= 1'b0;
			prev_first_ff <= 1'b0;
		end else begin
			prev_ones_ff  <= (mode == `MODE_WORD_TOGGLE)
				&& (accept ? (push_word == 12'hFFF) : prev_ones_ff);
			prev_alt_ff   <= in_alt_user && (accept || prev_alt_ff);
			prev_first_ff <= in_alt_user
				&& (accept ? (push_word == pattern_one_ff[15:4]) : prev_first_ff);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// assertions
	a_fixed_midscale: assert property (@(posedge clock) disable iff (!arst_n)
		accept && mode == `MODE_MIDSCALE |-> push_word == 12'h800)
		else $error("midscale word wrong");
	a_toggle_alternates: assert property (@(posedge clock) disable iff (!arst_n)
		accept && mode == `MODE_WORD_TOGGLE && prev_ones_ff
		|-> push_word == 12'h000)
		else $error("one/zero toggle did not alternate");
	a_single_repeats: assert property (@(posedge clock) disable iff (!arst_n)
		accept && mode == `MODE_USER && !alt |-> push_word == pattern_one_ff[15:4])
		else $error("single mode not first pattern");
	a_pattern_one_hi: assert property (@(posedge clock) disable iff (!arst_n)
		reg_wr.en && reg_wr.addr == 8'hC3 |=> pattern_one_ff[15:8] == $past(reg_wr.data))
		else $error("pattern one high byte not stored");
	a_pattern_two_lo: assert property (@(posedge clock) disable iff (!arst_n)
		reg_wr.en && reg_wr.addr == 8'hC4 ##1 reg_rd_en && reg_rd_addr == 8'hC4
		&& !(reg_wr.en && reg_wr.addr == 8'hC4) |=> reg_rd_data == $past(reg_wr.data, 2))
		else $error("pattern two low byte readback wrong");
	a_ddr_only_by_write: assert property (@(posedge clock) disable iff (!arst_n)
		$changed(ddr_enable) |-> $past(reg_wr.en && reg_wr.addr == 8'h74))
		else $error("ddr enable moved without a write");
	a_alternate_second: assert property (@(posedge clock) disable iff (!arst_n)
		accept && in_alt_user && prev_alt_ff
		|-> push_word == (prev_first_ff ? pattern_two_ff[15:4] : pattern_one_ff[15:4]))
		else $error("alternate user sequence broken");

	c_user_alternate: cover property (@(posedge clock) disable iff (!arst_n)
		accept && mode == `MODE_USER && alt && second);
	c_checker: cover property (@(posedge clock) disable iff (!arst_n)
		accept && mode == `MODE_CHECKER);
	c_fifo_full: cover property (@(posedge clock) disable iff (!arst_n)
		sample_valid && !sample_ready);
endmodule

`default_nettype wire

// *** bench/capture_model.sv ***
// capture logic model: takes output words, stalls when asked
`timescale 1ns/1ps
`default_nettype none
module capture_model (
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        stall,
	input  wire logic        out_valid,
	input  wire logic [11:0] out_data,
	output var  logic        out_ready
);
	logic [11:0] words [0:63];
	int          count = 0;
	//////////////////////////////////////////////////////////////////////
	// ready only moves off the sampling edge, so no race with the dut
	always @(negedge clock or negedge arst_n) begin
		if (!arst_n)
			out_ready <= 1'b0;
		else
			out_ready <= !stall;
	end
	always @(posedge clock) begin
		if (arst_n && out_valid && out_ready) begin
			words[count[5:0]] <= out_data;
			count <= count + 1;
		end
	end
endmodule
`default_nettype wire

// *** bench/adc_test_pattern_regs_test.sv ***
// self-checking testbench for the test pattern register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end
module adc_test_pattern_regs_test;
	logic                             clock;
	logic                             arst_n;
	adc_test_pattern_pkg::reg_write_s reg_wr;
	logic                             reg_rd_en;
	logic [7:0]                       reg_rd_addr;
	logic [7:0]                       reg_rd_data;
	logic                             sample_valid;
	logic [11:0]                      sample_data;
	logic                             sample_ready;
	logic                             out_valid;
	logic [11:0]                      out_data;
	logic                             out_ready;
	logic                             ddr_enable;
	logic                             stall;
	logic [7:0]                       v;
	int                               errors;
	int                               num_checks;
	int                               base;
	int                               n;
	logic [7:0]  modes [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h48, 8'h05, 8'h88};
	logic [11:0] exp0 [10] = '{12'h5A1, 12'h800, 12'hFFF, 12'h000, 12'hAAA, 12'hFFF, 12'h123,
		12'h123, 12'h5A1, 12'h123};
	logic [11:0] exp1 [10] = '{12'h5A2, 12'h800, 12'hFFF, 12'h000, 12'h555, 12'h000, 12'h123,
		12'hABC, 12'h5A2, 12'h123};
	adc_test_pattern_regs dut_u (.clock(clock), .arst_n(arst_n), .reg_wr(reg_wr),
		.reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
		.sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready),
		.out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
		.ddr_enable(ddr_enable));
	capture_model cap_u (.clock(clock), .arst_n(arst_n), .stall(stall), .out_valid(out_valid),
		.out_data(out_data), .out_ready(out_ready));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic timed_out();
		errors++;
		$display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		complete_run();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_wr = '{en: 1'b1, addr: a, data: d};
		@(negedge clock);
		reg_wr.en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_rd_en = 1'b1;
		reg_rd_addr = a;
		@(negedge clock);
		reg_rd_en = 1'b0;
		d = reg_rd_data;
	endtask
	// one sample, held until the fifo shows room
	task automatic send(input logic [11:0] d);
		int i;
		i = 0;
		@(negedge clock);
		sample_valid = 1'b1;
		sample_data = d;
		while (!sample_ready && i < 100) begin
			@(negedge clock);
			i++;
		end
		if (i == 100) timed_out();
		@(negedge clock);
		sample_valid = 1'b0;
	endtask
	task automatic wait_words(input int k);
		int i;
		i = 0;
		while (cap_u.count < k && i < 200) begin
			@(negedge clock);
			i++;
		end
		if (i == 200) timed_out();
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		errors = 0;
		num_checks = 0;
		arst_n = 1'b0;
		reg_wr = '0;
		reg_rd_en = 1'b0;
		reg_rd_addr = 8'h00;
		sample_valid = 1'b0;
		sample_data = 12'h000;
		stall = 1'b0;
		repeat (3) @(negedge clock);
		arst_n = 1'b1;
		// reset values, reserved and unmapped places read zero
		`CHK(ddr_enable, 1'b0)
		for (int a = 8'hC0; a <= 8'hC7; a++) begin
			rd(8'(a), v);
			`CHK(v, 8'h00)
		end
		$display("test reset_values done");
		wr(8'hC0, 8'h48);
		wr(8'hC1, 8'hFF);
		wr(8'hC2, 8'h34);
		wr(8'hC3, 8'h12);
		// read right behind the write, so the readback assertion is reached
		fork
			wr(8'hC4, 8'hCD);
			begin
				@(negedge clock);
				rd(8'hC4, v);
			end
		join
		`CHK(v, 8'hCD)
		wr(8'hC5, 8'hAB);
		wr(8'hC6, 8'hFF);
		rd(8'hC0, v);
		`CHK(v, 8'h48)
		rd(8'hC1, v);
		`CHK(v, 8'h00)
		rd(8'hC2, v);
		`CHK(v, 8'h34)
		rd(8'hC3, v);
		`CHK(v, 8'h12)
		rd(8'hC4, v);
		`CHK(v, 8'hCD)
		rd(8'hC5, v);
		`CHK(v, 8'hAB)
		rd(8'hC6, v);
		`CHK(v, 8'h00)
		wr(8'h74, 8'h10);
		`CHK(ddr_enable, 1'b1)
		$display("test register_access done");
		// every defined pattern code, two words each, plus reserved mode 5 and reserved sequence 2
		for (int m = 0; m < 10; m++) begin
			wr(8'hC0, modes[m]);
			base = cap_u.count;
			send(12'h5A1);
			send(12'h5A2);
			wait_words(base + 2);
			`CHK(cap_u.words[base], exp0[m])
			`CHK(cap_u.words[base + 1], exp1[m])
		end
		$display("test pattern_modes done");
		// fill the fifo while the capture side stalls, then drain in order
		wr(8'hC0, 8'h00);
		stall = 1'b1;
		base = cap_u.count;
		n = 0;
		for (int k = 0; k < 40; k++) begin
			@(negedge clock);
			sample_valid = sample_ready;
			sample_data = 12'(12'h100 + n);
			if (sample_ready) n++;
		end
		@(negedge clock);
		sample_valid = 1'b0;
		`CHK(sample_ready, 1'b0)
		`CHK(1'(n >= 16), 1'b1)
		stall = 1'b0;
		wait_words(base + n);
		for (int k = 0; k < n; k++)
			`CHK(cap_u.words[(base + k) % 64], 12'(12'h100 + k))
		$display("test fifo_fill done");
		// second reset clears the patterns again
		@(negedge clock);
		arst_n = 1'b0;
		repeat (2) @(negedge clock);
		arst_n = 1'b1;
		rd(8'hC5, v);
		`CHK(v, 8'h00)
		`CHK(ddr_enable, 1'b0)
		$display("test second_reset done");
		complete_run();
	end
endmodule
`default_nettype wire
